// >>> design/bcdp_pkg.sv
package bcdp_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned SET_MS = 30;
  localparam int unsigned VALID_MS = 40;
  localparam int unsigned RELEASE_MS = 16;
  localparam int unsigned PERIOD_MS = 64;
  localparam int unsigned DIGITS = 5;
  localparam int unsigned DATA_W = 4 * DIGITS;
  localparam int unsigned MS_W = 8;
  localparam int unsigned TICK_W = 16;
  localparam logic [DATA_W-1:0] DATA_OFF = 20'h00000;
endpackage

// >>> design/bcdp_buf2.sv
`timescale 1ns/1ps
module bcdp_buf2 #(
  parameter int unsigned WIDTH = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } bcdp_buf_type;
  bcdp_buf_type s_q;
  bcdp_buf_type s_d;
  logic push;
  logic pop;
  assign in_ready = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = ~s_q.wr;
    end
    if (pop)
      s_d.rd = ~s_q.rd;
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule // bcdp_buf2

// >>> design/bcdp_port.sv
`timescale 1ns/1ps
// Operation
// RULE_01: data only presented after the reader asserts demand.
// RULE_02: data and strobe asserted 30 ms after demand rises; here data loads in the set phase, strobe at 30 ms.
// RULE_03: single sample strobe drops 40 ms after it rose.
// RULE_04: single sample data released 16 ms after strobe drops.
// RULE_05: while demand held, a fresh value is output every 64 ms.
// RULE_06: freeze during change gives old or new value, never off.
// RULE_07: reader samples data only while strobe is asserted.
// RULE_08: reader waits 20 ms after strobe drops before next demand.
// RULE_09: demand and freeze inputs are active low.
// RULE_10: delays from a millisecond tick; inputs synchronised first.
module bcdp_port
  import bcdp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = bcdp_pkg::TICK_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic REQUEST_N,
  input wire logic FREEZE_N,
  input wire logic [bcdp_pkg::DATA_W-1:0] MEAS_BCD,
  input wire logic MEAS_NEG,
  input wire logic MEAS_VALID,
  output logic MEAS_READY,
  output logic [bcdp_pkg::DATA_W-1:0] BCD_DATA,
  output logic BCD_NEG,
  output logic DATA_STROBE
);
  import bcdp_pkg::*;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SET = 2'b01,
    ST_VALID = 2'b10,
    ST_HOLD = 2'b11
  } bcdp_st_type;
  typedef struct packed {
    logic [2:0] req_s;
    logic [2:0] frz_s;
    logic req_q;
    logic frz_q;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [MS_W-1:0] ms;
    bcdp_st_type st;
    logic [DATA_W-1:0] data;
    logic neg;
    logic strobe;
  } bcdp_state_type;
  bcdp_state_type s_q;
  bcdp_state_type s_d;
  logic buf_valid;
  logic buf_take;
  logic [DATA_W:0] buf_data;
  logic req_rise;
  function automatic logic ms_done(input logic tick, input logic [MS_W-1:0] ms,
                                   input int unsigned lim);
    ms_done = tick && (ms == MS_W'(lim - 1));
  endfunction
  bcdp_buf2 #(
    .WIDTH(DATA_W + 1)
  ) u_buf (
    .clk(REF_CLK),
    .rst(RESET),
    .in_valid(MEAS_VALID),
    .in_ready(MEAS_READY),
    .in_data({MEAS_NEG, MEAS_BCD}),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );
  // stage 1 only feeds stage 2; agreement of stages 2 and 3 qualifies a change
  assign req_rise = s_d.req_q && !s_q.req_q;
  // set phase drains to the newest word;
  // continuous output pops at most one word per period, none while frozen, so a stall loses nothing
  assign buf_take = s_q.req_q && !s_q.frz_q &&
                    (s_q.st == ST_SET ||
                     (s_q.st == ST_VALID && ms_done(s_q.tick, s_q.ms, PERIOD_MS))); // RULE_05
  always_comb
  begin
    s_d = s_q;
    s_d.req_s = {s_q.req_s[1:0], ~REQUEST_N}; // RULE_09 RULE_10
    s_d.frz_s = {s_q.frz_s[1:0], ~FREEZE_N}; // RULE_09 RULE_10
    if (s_q.req_s[2] == s_q.req_s[1])
      s_d.req_q = s_q.req_s[2];
    if (s_q.frz_s[2] == s_q.frz_s[1])
      s_d.frz_q = s_q.frz_s[2];
    s_d.tick = (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1)); // RULE_10
    s_d.tick_cnt = s_d.tick ? '0 : s_q.tick_cnt + 1'b1;
    if (s_q.tick)
      s_d.ms = s_q.ms + 1'b1;
    if (buf_take && buf_valid && s_q.st == ST_SET)
    begin
      s_d.data = buf_data[DATA_W-1:0];
      s_d.neg = buf_data[DATA_W];
    end
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (req_rise) // RULE_01
        begin
          s_d.st = ST_SET;
          s_d.ms = '0;
        end
      end
      ST_SET:
      begin
        if (ms_done(s_q.tick, s_q.ms, SET_MS)) // RULE_02
        begin
          s_d.st = ST_VALID;
          s_d.strobe = 1'b1;
          s_d.ms = '0;
        end
      end
      ST_VALID:
      begin
        if (s_q.req_q)
        begin
          // continuous: reload value each period unless frozen or no word is buffered, data never goes off
          if (ms_done(s_q.tick, s_q.ms, PERIOD_MS)) // RULE_05
          begin
            s_d.ms = '0;
            if (buf_valid && !s_q.frz_q) // RULE_06
            begin
              s_d.data = buf_data[DATA_W-1:0];
              s_d.neg = buf_data[DATA_W];
            end
          end
        end
        // late release in continuous mode waits for the count to wrap
        else if (ms_done(s_q.tick, s_q.ms, VALID_MS)) // RULE_03
        begin
          s_d.st = ST_HOLD;
          s_d.strobe = 1'b0;
          s_d.ms = '0;
        end
      end
      ST_HOLD:
      begin
        if (ms_done(s_q.tick, s_q.ms, RELEASE_MS)) // RULE_04
        begin
          s_d.st = ST_IDLE;
          s_d.data = DATA_OFF;
          s_d.neg = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign BCD_DATA = s_q.data;
  assign BCD_NEG = s_q.neg;
  assign DATA_STROBE = s_q.strobe;
  AST_STROBE_NEEDS_DEMAND: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_01
    $rose(s_q.strobe) |-> s_q.st == ST_VALID && $past(s_q.st) == ST_SET)
    else $error("strobe rose without a demand sequence");
  AST_STROBE_NOT_IDLE: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_07
    s_q.strobe |-> s_q.st == ST_VALID)
    else $error("strobe outside valid state");
  AST_OFF_WHEN_IDLE: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_04
    $fell(s_q.st == ST_HOLD) |-> s_q.data == DATA_OFF && !s_q.strobe)
    else $error("data not released after hold");
  AST_SET_TIME: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_02
    $rose(s_q.strobe) |-> s_q.ms == '0 && $past(s_q.ms) == MS_W'(SET_MS - 1))
    else $error("strobe delay wrong");
  AST_VALID_TIME: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_03
    $fell(s_q.strobe) |-> $past(s_q.ms) == MS_W'(VALID_MS - 1) && s_q.st == ST_HOLD)
    else $error("strobe width wrong");
  AST_NO_DROP_WHILE_HELD: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_06
    s_q.st == ST_VALID && s_q.req_q |=> s_q.st == ST_VALID)
    else $error("output dropped during continuous output");
  AST_FREEZE_KEEPS: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_06
    s_q.st == ST_VALID && s_q.frz_q |=> $stable(s_q.data))
    else $error("data changed while frozen");
  AST_PERIOD: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_05
    s_q.st == ST_VALID && s_q.req_q |-> s_q.ms < MS_W'(PERIOD_MS))
    else $error("refresh period exceeded");
  AST_DATA_ONLY_AT_PERIOD: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_05
    s_q.st == ST_VALID && !ms_done(s_q.tick, s_q.ms, PERIOD_MS) |=> $stable(s_q.data))
    else $error("data changed between refresh points");
  AST_HOLD_TIME: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_04
    $fell(s_q.st == ST_HOLD) |-> $past(s_q.ms) == MS_W'(RELEASE_MS - 1))
    else $error("release delay wrong");
  AST_POP_NEEDS_DEMAND: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_01
    buf_take |-> s_q.req_q)
    else $error("measurement taken without demand");
  AST_NO_POP_FROZEN: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_06
    s_q.frz_q |-> !buf_take)
    else $error("measurement taken while frozen");
  AST_IDLE_QUIET: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_01
    s_q.st == ST_IDLE |-> !s_q.strobe && s_q.data == DATA_OFF && !s_q.neg)
    else $error("outputs active while idle");
  AST_SET_ENTRY: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_01
    $rose(s_q.st == ST_SET) |-> $past(s_q.st) == ST_IDLE && s_q.req_q && s_q.ms == '0)
    else $error("set phase entered without demand");
  AST_SET_BOUND: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_02
    s_q.st == ST_SET |-> s_q.ms < MS_W'(SET_MS))
    else $error("set phase overran");
  AST_HOLD_BOUND: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_04
    s_q.st == ST_HOLD |-> s_q.ms < MS_W'(RELEASE_MS) && !s_q.strobe)
    else $error("hold phase overran");
  // the timing base and input qualifiers are checked here as well
  AST_REQ_QUALIFIED: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_10
    $changed(s_q.req_q) |-> $past(s_q.req_s[2]) == $past(s_q.req_s[1]))
    else $error("demand changed without agreement");
  AST_FRZ_QUALIFIED: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_10
    $changed(s_q.frz_q) |-> $past(s_q.frz_s[2]) == $past(s_q.frz_s[1]))
    else $error("freeze changed without agreement");
  AST_TICK_RESTART: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_10
    s_q.tick |-> s_q.tick_cnt == '0)
    else $error("tick counter not restarted");
  AST_MS_ON_TICK: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_10
    !$past(s_q.tick) && $stable(s_q.st) |-> $stable(s_q.ms))
    else $error("millisecond count moved without tick");
  AST_TICK: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_10
    s_q.tick |=> !s_q.tick)
    else $error("tick longer than one cycle");
endmodule // bcdp_port

// >>> sim/bcdp_reader.sv
`timescale 1ns/1ps
module bcdp_reader
  import bcdp_pkg::*;
#(
  parameter int unsigned GAP = 80
) (
  input wire logic clk,
  input wire logic want,
  input wire logic strobe,
  input wire logic [bcdp_pkg::DATA_W-1:0] data,
  output logic req_n,
  output logic [bcdp_pkg::DATA_W-1:0] seen
);
  // gap is 20 ms at 4 cycles per ms
  int unsigned gap_cnt = GAP;
  initial req_n = 1'b1;
  initial seen = '0;
  always @(posedge clk)
  begin
    if (strobe)
      gap_cnt <= 0;
    else if (gap_cnt < GAP)
      gap_cnt <= gap_cnt + 1;
    req_n <= #1 !(want && (!req_n || gap_cnt >= GAP));
    if (strobe)
      seen <= data;
  end
endmodule // bcdp_reader

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bcdp_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic want = 0;
  logic frz_n = 1;
  logic mv = 0;
  logic mneg = 0;
  logic off_seen = 0;
  logic [DATA_W-1:0] mbcd = '0;
  logic req_n, mrdy, bneg, stb;
  logic [DATA_W-1:0] bdat, seen;
  int error_cnt = 0;
  int checks = 0;
  int n;
  always #25 clk = ~clk;
  bcdp_port #(.TICK_CYCLES(4)) dut (.REF_CLK(clk), .RESET(rst), .REQUEST_N(req_n),
    .FREEZE_N(frz_n), .MEAS_BCD(mbcd), .MEAS_NEG(mneg), .MEAS_VALID(mv),
    .MEAS_READY(mrdy), .BCD_DATA(bdat), .BCD_NEG(bneg), .DATA_STROBE(stb));
  bcdp_reader rdr (.clk(clk), .want(want), .strobe(stb), .data(bdat), .req_n(req_n),
    .seen(seen));
  always @(posedge clk)
    if (stb === 1'b1 && bdat === DATA_OFF) off_seen <= 1'b1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic push(input logic [DATA_W:0] w);
    {mneg, mbcd} = w;
    mv = 1;
    while (mrdy !== 1'b1) step(1);
    step(1);
    mv = 0;
    step(1);
  endtask
  // counts cycles until strobe or data reaches v
  task automatic wait_for(input bit on_data, input logic [DATA_W-1:0] v);
    n = 0;
    while ((on_data ? bdat !== v : stb !== v[0]) && n < 2000)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic t_single;
    push({1'b1, 20'h12345});
    push({1'b0, 20'h67890});
    check(mrdy, 0);
    step(200);
    check({stb, bdat}, {1'b0, DATA_OFF});
    want = 1;
    wait_for(0, 1);
    check(n >= 120 && n <= 134, 1);
    check({bneg, bdat}, 21'h067890);
    want = 0;
    wait_for(0, 0);
    check(n >= 159 && n <= 161, 1);
    wait_for(1, DATA_OFF);
    check(n >= 63 && n <= 65, 1);
  endtask
  task automatic t_cont;
    push({1'b0, 20'h24680});
    want = 1;
    wait_for(0, 1);
    check(bdat, 20'h24680);
    push({1'b0, 20'h11111});
    wait_for(1, 20'h11111);
    check(n >= 250 && n <= 257, 1);
    step(1);
    check(seen, 20'h11111);
    frz_n = 0;
    push({1'b0, 20'h13579});
    step(300);
    check(bdat, 20'h11111);
    frz_n = 1;
    wait_for(1, 20'h13579);
    check(n <= 257, 1);
    check(off_seen, 0);
    want = 0;
    wait_for(0, 0);
    check(n >= 159 && n <= 161, 1);
    wait_for(1, DATA_OFF);
    check(n >= 63 && n <= 65, 1);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    step(2);
    rst = 0;
    t_single;
    t_cont;
    complete_run;
  end
  // about ten times the expected run
  initial
  begin
    #1000000;
    error_cnt++;
    complete_run;
  end
endmodule // testbench
